// ===== hw/acrb_bank.sv
// Configuration register bank with offset loop, low-speed gating and latency pipe.
`timescale 1ns/10ps
// ============================================================================
module acrb_bank
    import acrb_pkg::*;
#(
    parameter int WAKEUP_COUNT = WAKEUP_CYCLES,
    parameter int LATENCY      = PIPE_LATENCY
) (
    input  wire logic        pclk,            // APB and sample clock
    input  wire logic        presetn,         // Asynchronous reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB access phase
    input  wire logic        pwrite,          // APB write
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error on unmapped address
    input  wire logic [13:0] raw_a,           // Channel A quantised sample
    input  wire logic [13:0] raw_b,           // Channel B quantised sample
    output logic      [13:0] data_out_a,      // Channel A output code
    output logic      [13:0] data_out_b,      // Channel B output code
    output logic             data_valid,      // Output codes are live
    output logic             data_double_drive, // Output buffers at double strength
    output logic             analog_enable,   // Channels, references and buffers powered
    output logic             high_freq_a,     // Channel A high-frequency mode
    output logic             high_freq_b,     // Channel B high-frequency mode
    output logic             slow_mode_a,     // Channel A low-speed mode in effect
    output logic             slow_mode_b,     // Channel B low-speed mode in effect
    output logic             swing_override,  // Swing code is in force
    output logic      [5:0]  swing_code       // Applied differential swing code
);

    // ========================================================================
    // Register storage.
    logic [7:0] power_and_drive_control, next_power_and_drive_control;
    logic [7:0] high_freq_select_b, next_high_freq_select_b;
    logic [7:0] high_freq_select_a, next_high_freq_select_a;
    logic [7:0] offset_bias_a_reg, next_offset_bias_a_reg;
    logic [7:0] offset_bias_b_reg, next_offset_bias_b_reg;
    logic [7:0] offset_loop_control, next_offset_loop_control;
    logic [7:0] slow_rate_b_reg, next_slow_rate_b_reg;
    logic [7:0] slow_rate_master_reg, next_slow_rate_master_reg;
    logic [7:0] swing_override_reg, next_swing_override_reg;
    logic [7:0] slow_rate_a_reg, next_slow_rate_a_reg;
    logic [7:0] aux_control, next_aux_control;

    logic       wr_en;
    logic       mapped;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;

    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Unassigned bits are masked off here, so a host slip on them is harmless.
    function automatic logic [7:0] wr_field(input logic [7:0] cur, input logic [7:0] mask,
                                            input logic hit);
        return hit ? (pwdata[7:0] & mask) : cur;
    endfunction

    always_comb begin
        next_power_and_drive_control = wr_field(power_and_drive_control, MASK_POWER_DRIVE,
                                               wr_en && paddr == OFS_POWER_DRIVE);
        next_high_freq_select_b   = wr_field(high_freq_select_b, MASK_HF_SELECT,
                                             wr_en && paddr == OFS_HF_SELECT_B);
        next_high_freq_select_a   = wr_field(high_freq_select_a, MASK_HF_SELECT,
                                             wr_en && paddr == OFS_HF_SELECT_A);
        next_offset_bias_a_reg    = wr_field(offset_bias_a_reg, MASK_BIAS,
                                             wr_en && paddr == OFS_BIAS_A);
        next_offset_bias_b_reg    = wr_field(offset_bias_b_reg, MASK_BIAS,
                                             wr_en && paddr == OFS_BIAS_B);
        next_offset_loop_control  = wr_field(offset_loop_control, MASK_LOOP_CONTROL,
                                             wr_en && paddr == OFS_LOOP_CONTROL);
        next_slow_rate_b_reg      = wr_field(slow_rate_b_reg, MASK_SLOW_B,
                                             wr_en && paddr == OFS_SLOW_B);
        next_slow_rate_master_reg = wr_field(slow_rate_master_reg, MASK_SLOW_MASTER,
                                             wr_en && paddr == OFS_SLOW_MASTER);
        next_swing_override_reg   = wr_field(swing_override_reg, MASK_SWING_ENABLE,
                                             wr_en && paddr == OFS_SWING_ENABLE);
        next_slow_rate_a_reg      = wr_field(slow_rate_a_reg, MASK_SLOW_A,
                                             wr_en && paddr == OFS_SLOW_A);
        next_aux_control          = wr_field(aux_control, MASK_AUX_CONTROL,
                                             wr_en && paddr == OFS_AUX_CONTROL);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_and_drive_control <= RESET_VALUE;
            high_freq_select_b      <= RESET_VALUE;
            high_freq_select_a      <= RESET_VALUE;
            offset_bias_a_reg       <= RESET_VALUE;
            offset_bias_b_reg       <= RESET_VALUE;
            offset_loop_control     <= RESET_VALUE;
            slow_rate_b_reg         <= RESET_VALUE;
            slow_rate_master_reg    <= RESET_VALUE;
            swing_override_reg      <= RESET_VALUE;
            slow_rate_a_reg         <= RESET_VALUE;
            aux_control             <= RESET_VALUE;
        end else begin
            power_and_drive_control <= next_power_and_drive_control;
            high_freq_select_b      <= next_high_freq_select_b;
            high_freq_select_a      <= next_high_freq_select_a;
            offset_bias_a_reg       <= next_offset_bias_a_reg;
            offset_bias_b_reg       <= next_offset_bias_b_reg;
            offset_loop_control     <= next_offset_loop_control;
            slow_rate_b_reg         <= next_slow_rate_b_reg;
            slow_rate_master_reg    <= next_slow_rate_master_reg;
            swing_override_reg      <= next_swing_override_reg;
            slow_rate_a_reg         <= next_slow_rate_a_reg;
            aux_control             <= next_aux_control;
        end
    end

    // ========================================================================
    // Read mux.
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            OFS_POWER_DRIVE:  rd_byte = power_and_drive_control;
            OFS_HF_SELECT_B:  rd_byte = high_freq_select_b;
            OFS_HF_SELECT_A:  rd_byte = high_freq_select_a;
            OFS_BIAS_A:       rd_byte = offset_bias_a_reg;
            OFS_BIAS_B:       rd_byte = offset_bias_b_reg;
            OFS_LOOP_CONTROL: rd_byte = offset_loop_control;
            OFS_SLOW_B:       rd_byte = slow_rate_b_reg;
            OFS_SLOW_MASTER:  rd_byte = slow_rate_master_reg;
            OFS_SWING_ENABLE: rd_byte = swing_override_reg;
            OFS_SLOW_A:       rd_byte = slow_rate_a_reg;
            OFS_AUX_CONTROL:  rd_byte = aux_control;
            OFS_STATUS:       rd_byte = status_byte;
            default:          mapped  = 1'b0;
        endcase
        prdata = {24'h000000, rd_byte};
    end

    // ========================================================================
    // Power sequencing; wakeup waits the slow figure before data is live.
    acrb_power_type power_state, next_power_state;
    logic [31:0]    wake_count, next_wake_count;
    logic           pdn_bit;

    assign pdn_bit = power_and_drive_control[BIT_POWER_DOWN];

    always_comb begin
        next_power_state = power_state;
        next_wake_count  = wake_count;
        case (power_state)
            ACRB_PWR_ON:   if (pdn_bit) next_power_state = ACRB_PWR_DOWN;
            ACRB_PWR_DOWN: if (!pdn_bit) begin
                next_power_state = ACRB_PWR_WAKE;
                next_wake_count  = 32'h0;
            end
            ACRB_PWR_WAKE: begin
                if (pdn_bit) begin
                    next_power_state = ACRB_PWR_DOWN;
                end else if (wake_count >= 32'(WAKEUP_COUNT - 1)) begin
                    next_power_state = ACRB_PWR_ON;
                end else begin
                    next_wake_count = wake_count + 32'h1;
                end
            end
            default: next_power_state = ACRB_PWR_ON;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state <= ACRB_PWR_ON;
            wake_count  <= 32'h0;
        end else begin
            power_state <= next_power_state;
            wake_count  <= next_wake_count;
        end
    end

    assign analog_enable = (power_state == ACRB_PWR_ON);

    // ========================================================================
    // Mode outputs.
    logic slow_master;
    assign slow_master       = slow_rate_master_reg[BIT_SLOW_MASTER];
    assign data_double_drive = power_and_drive_control[BIT_DATA_DOUBLE];
    assign high_freq_a       = high_freq_select_a[BIT_HF_SELECT];
    assign high_freq_b       = high_freq_select_b[BIT_HF_SELECT];
    assign slow_mode_a       = slow_master & slow_rate_a_reg[BIT_SLOW_A];
    assign slow_mode_b       = slow_master & slow_rate_b_reg[BIT_SLOW_B];
    // Codes 01 and 10 are illegal; only 11 hands control to the swing code.
    assign swing_override    = (swing_override_reg[SWING_MSB:SWING_LSB] == SWING_ON);
    assign swing_code        = swing_override ? aux_control[SWING_CODE_MSB:SWING_CODE_LSB]
                                              : 6'h00;
    assign status_byte       = {5'h00, slow_mode_b, slow_mode_a, analog_enable};

    // ========================================================================
    // Offset loop per channel. The estimate is a leaky average of the error
    // between the sample and midcode; the shift sets the time constant.
    logic loop_on, hold_est, digital_on, fmt_offset;
    logic [3:0] tc;
    assign digital_on = aux_control[BIT_DIGITAL_EN];
    assign loop_on    = digital_on & aux_control[BIT_LOOP_ENABLE];
    assign hold_est   = offset_loop_control[BIT_HOLD_ESTIMATE];
    assign tc         = offset_loop_control[TC_MSB:TC_LSB];
    assign fmt_offset = aux_control[BIT_OFFSET_BINARY];

    // Estimate carries 16 fraction bits so long time constants do not stall.
    function automatic logic signed [31:0] next_est(input logic signed [31:0] est,
                                                    input logic [13:0] raw);
        logic signed [31:0] err;
        err = ($signed({18'h0, raw}) - $signed({18'h0, MIDCODE})) <<< 16;
        return est + ((err - est) >>> tc);
    endfunction

    // Corrected code: sample minus estimate plus pedestal, saturated.
    function automatic logic [13:0] correct(input logic [13:0] raw,
                                            input logic signed [31:0] est,
                                            input logic [7:0] bias_reg);
        logic signed [31:0] v;
        v = $signed({18'h0, raw}) - (est >>> 16)
            + 32'(signed'(bias_reg[BIAS_MSB:BIAS_LSB]));
        if (v < 0) v = 0;
        if (v > 32'sd16383) v = 32'sd16383;
        return v[13:0];
    endfunction

    logic signed [31:0] est_a, est_b, next_est_a, next_est_b;
    logic [13:0] proc_a, proc_b;

    always_comb begin
        next_est_a = est_a;
        next_est_b = est_b;
        if (loop_on && !hold_est) begin
            next_est_a = next_est(est_a, raw_a);
            next_est_b = next_est(est_b, raw_b);
        end
        proc_a = loop_on ? correct(raw_a, est_a, offset_bias_a_reg) : raw_a;
        proc_b = loop_on ? correct(raw_b, est_b, offset_bias_b_reg) : raw_b;
        if (!fmt_offset) begin
            proc_a = proc_a ^ 14'h2000;
            proc_b = proc_b ^ 14'h2000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            est_a <= 32'sh0;
            est_b <= 32'sh0;
        end else begin
            est_a <= next_est_a;
            est_b <= next_est_b;
        end
    end

    // ========================================================================
    // Latency pipe: both channels enter on the same edge and leave together.
    logic [13:0] pipe_a [LATENCY];
    logic [13:0] pipe_b [LATENCY];
    logic [LATENCY-1:0] pipe_v;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_a[i] <= 14'h0000;
                pipe_b[i] <= 14'h0000;
            end
            pipe_v <= '0;
        end else begin
            pipe_a[0] <= proc_a;
            pipe_b[0] <= proc_b;
            pipe_v[0] <= analog_enable;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_a[i] <= pipe_a[i-1];
                pipe_b[i] <= pipe_b[i-1];
                pipe_v[i] <= pipe_v[i-1] & analog_enable;
            end
        end
    end

    assign data_out_a = analog_enable ? pipe_a[LATENCY-1] : 14'h0000;
    assign data_out_b = analog_enable ? pipe_b[LATENCY-1] : 14'h0000;
    assign data_valid = pipe_v[LATENCY-1];

endmodule // acrb_bank

// ===== hw/acrb_pkg.sv
// Package for the converter configuration register bank: offsets, fields and timing.
package acrb_pkg;

    // ========================================================================
    // Register byte offsets on APB (each register one aligned word).
    localparam logic [7:0] OFS_POWER_DRIVE   = 8'h00;
    localparam logic [7:0] OFS_HF_SELECT_B   = 8'h04;
    localparam logic [7:0] OFS_HF_SELECT_A   = 8'h08;
    localparam logic [7:0] OFS_BIAS_A        = 8'h0c;
    localparam logic [7:0] OFS_BIAS_B        = 8'h10;
    localparam logic [7:0] OFS_LOOP_CONTROL  = 8'h14;
    localparam logic [7:0] OFS_SLOW_B        = 8'h18;
    localparam logic [7:0] OFS_SLOW_MASTER   = 8'h1c;
    localparam logic [7:0] OFS_SWING_ENABLE  = 8'h20;
    localparam logic [7:0] OFS_SLOW_A        = 8'h24;
    localparam logic [7:0] OFS_AUX_CONTROL   = 8'h28;
    localparam logic [7:0] OFS_STATUS        = 8'h2c;

    // ========================================================================
    // Field positions.
    localparam int BIT_DATA_DOUBLE   = 5;
    localparam int BIT_POWER_DOWN    = 2;
    localparam int BIT_HF_SELECT     = 0;
    localparam int BIT_HOLD_ESTIMATE = 7;
    localparam int TC_LSB            = 2;
    localparam int TC_MSB            = 5;
    localparam int BIAS_LSB          = 2;
    localparam int BIAS_MSB          = 7;
    localparam int BIT_SLOW_B        = 0;
    localparam int BIT_SLOW_A        = 3;
    localparam int BIT_SLOW_MASTER   = 4;
    localparam int SWING_LSB         = 0;
    localparam int SWING_MSB         = 1;
    localparam int SWING_CODE_LSB    = 2;
    localparam int SWING_CODE_MSB    = 7;
    localparam int BIT_LOOP_ENABLE   = 5;
    localparam int BIT_DIGITAL_EN    = 3;
    localparam int BIT_OFFSET_BINARY = 0;

    // Per-register writable masks; all other bits read zero.
    localparam logic [7:0] MASK_POWER_DRIVE  = 8'h24;
    localparam logic [7:0] MASK_HF_SELECT    = 8'h01;
    localparam logic [7:0] MASK_BIAS         = 8'hfc;
    localparam logic [7:0] MASK_LOOP_CONTROL = 8'hbc;
    localparam logic [7:0] MASK_SLOW_B       = 8'h01;
    localparam logic [7:0] MASK_SLOW_MASTER  = 8'h10;
    localparam logic [7:0] MASK_SWING_ENABLE = 8'h03;
    localparam logic [7:0] MASK_SLOW_A       = 8'h08;
    localparam logic [7:0] MASK_AUX_CONTROL  = 8'hfd;

    localparam logic [7:0] RESET_VALUE       = 8'h00;
    localparam logic [1:0] SWING_ON          = 2'h3;

    // ========================================================================
    // Converter data path and timing.
    localparam int  DATA_WIDTH        = 14;
    localparam int  PIPE_LATENCY      = 16;
    localparam int  CLOCK_MHZ         = 100;
    localparam int  WAKEUP_US         = 100;
    localparam int  WAKEUP_CYCLES     = WAKEUP_US * CLOCK_MHZ;
    localparam logic [13:0] MIDCODE   = 14'h2000;

    typedef enum logic [1:0] {
        ACRB_PWR_ON,
        ACRB_PWR_DOWN,
        ACRB_PWR_WAKE
    } acrb_power_type;

endpackage

// ===== testbench/acrb_bank_assertions.sv
// Concurrent checks on the ports of the converter configuration register bank.
`timescale 1ns/10ps
module acrb_bank_assertions
    import acrb_pkg::*;
(
    input wire logic        pclk,              // Clock
    input wire logic        presetn,           // Reset, active low
    input wire logic        psel,              // APB select
    input wire logic        penable,           // APB access phase
    input wire logic        pwrite,            // APB write
    input wire logic [7:0]  paddr,             // APB address
    input wire logic [31:0] pwdata,            // APB write data
    input wire logic [31:0] prdata,            // APB read data
    input wire logic [13:0] data_out_a,        // Channel A code
    input wire logic [13:0] data_out_b,        // Channel B code
    input wire logic        data_valid,        // Codes live
    input wire logic        data_double_drive, // Double strength
    input wire logic        analog_enable,     // Powered
    input wire logic        high_freq_a,       // Channel A high-frequency mode
    input wire logic        slow_mode_a,       // Channel A low-speed mode
    input wire logic        slow_mode_b,       // Channel B low-speed mode
    input wire logic        swing_override     // Swing code in force
);
    // ========================================================================
    // Helpers
    logic       wr;
    logic [7:0] wd;
    logic [7:0] last_wd;
    assign wr = psel && penable && pwrite;
    assign wd = pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_wd <= 8'h00;
        end else begin
            last_wd <= wd;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ========================================================================
    // Properties
    property p_drive;
        wr && paddr == OFS_POWER_DRIVE |=> data_double_drive == last_wd[BIT_DATA_DOUBLE];
    endproperty
    a_drive: assert property (p_drive) else $error("drive strength mismatch");
    property p_power_down;
        wr && paddr == OFS_POWER_DRIVE && wd[BIT_POWER_DOWN] |-> ##2 !analog_enable;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down ignored");
    property p_out_quiet;
        !analog_enable ##1 !analog_enable |-> data_out_a == 14'h0000 && data_out_b == 14'h0000;
    endproperty
    a_out_quiet: assert property (p_out_quiet) else $error("outputs live while down");
    property p_high_freq;
        wr && paddr == OFS_HF_SELECT_A |=> high_freq_a == last_wd[BIT_HF_SELECT];
    endproperty
    a_high_freq: assert property (p_high_freq) else $error("high freq select mismatch");
    property p_slow_off;
        wr && paddr == OFS_SLOW_MASTER && !wd[BIT_SLOW_MASTER] |=> !slow_mode_a && !slow_mode_b;
    endproperty
    a_slow_off: assert property (p_slow_off) else $error("slow mode without master");
    property p_swing;
        wr && paddr == OFS_SWING_ENABLE |=> swing_override == (last_wd[1:0] == SWING_ON);
    endproperty
    a_swing: assert property (p_swing) else $error("swing override mismatch");
    property p_latency;
        $rose(analog_enable) |-> !data_valid [*8] ##[1:12] data_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("valid not after pipe fill");
    property p_bias_mask;
        psel && penable && !pwrite && paddr == OFS_BIAS_A |-> prdata[1:0] == 2'h0;
    endproperty
    a_bias_mask: assert property (p_bias_mask) else $error("pedestal low bits set");
endmodule // acrb_bank_assertions

bind acrb_bank acrb_bank_assertions u_acrb_bank_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .data_out_a(data_out_a),
    .data_out_b(data_out_b), .data_valid(data_valid), .data_double_drive(data_double_drive),
    .analog_enable(analog_enable), .high_freq_a(high_freq_a), .slow_mode_a(slow_mode_a),
    .slow_mode_b(slow_mode_b), .swing_override(swing_override));

// ===== testbench/acrb_host_model.sv
// Host model that programs the register bank through APB transfers.
`timescale 1ns/10ps
module acrb_host_model (
    input  wire logic        pclk,    // Bus clock
    input  wire logic        pready,  // Slave ready
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pslverr, // Slave error
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Direction
    output logic      [7:0]  paddr,   // Byte address
    output logic      [31:0] pwdata   // Write data
);
    int stalls = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // An idle edge precedes every setup, so no signal is assigned twice in one step.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d; // Callers keep unassigned bits at zero.
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            stalls++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // acrb_host_model

// ===== testbench/tb_acrb_bank.sv
// Self-checking testbench for the converter configuration register bank.
`timescale 1ns/10ps
module tb_acrb_bank;
    import acrb_pkg::*;
    localparam int WK = 8;
    typedef struct packed {logic [7:0] addr; logic [7:0] data;} acrb_row_type;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic        data_valid, data_double_drive, analog_enable, high_freq_a, high_freq_b;
    logic        slow_mode_a, slow_mode_b, swing_override, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [13:0] raw_a = 14'h0000, raw_b = 14'h3fff, data_out_a, data_out_b, flip;
    logic [5:0]  swing_code;
    logic [13:0] hist_a[$], hist_b[$];
    int          mismatches = 0, tests_run = 0, n, k;
    // Master enable is written before the per-channel low-speed bits.
    acrb_row_type rows [10] = '{'{OFS_POWER_DRIVE, 8'h20}, '{OFS_HF_SELECT_B, 8'h01},
        '{OFS_HF_SELECT_A, 8'h01}, '{OFS_BIAS_A, 8'hfc}, '{OFS_BIAS_B, 8'h80},
        '{OFS_LOOP_CONTROL, 8'hbc}, '{OFS_SLOW_MASTER, 8'h10}, '{OFS_SLOW_B, 8'h01},
        '{OFS_SWING_ENABLE, 8'h03}, '{OFS_SLOW_A, 8'h08}};

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        hist_a.push_back(raw_a);
        hist_b.push_back(raw_b);
        raw_a <= raw_a + 14'h0123;
        raw_b <= raw_b - 14'h0057;
    end

    acrb_host_model u_acrb_host_model (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    acrb_bank #(.WAKEUP_COUNT(WK)) u_acrb_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .raw_a(raw_a), .raw_b(raw_b),
        .data_out_a(data_out_a), .data_out_b(data_out_b), .data_valid(data_valid),
        .data_double_drive(data_double_drive), .analog_enable(analog_enable),
        .high_freq_a(high_freq_a), .high_freq_b(high_freq_b), .slow_mode_a(slow_mode_a),
        .slow_mode_b(slow_mode_b), .swing_override(swing_override), .swing_code(swing_code));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        x;
        u_acrb_host_model.xfer(1'b1, a, {24'h0, d}, r, x);
    endtask
    task automatic rd(input logic [7:0] a);
        u_acrb_host_model.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task automatic close_out;
        mismatches += u_acrb_host_model.stalls;
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].addr);
            check("reset value", q, 32'h0);
        end
        rd(OFS_STATUS);
        check("status after reset", q, 32'h1);
        // ====================================================================
        // Table of legal writes, each read back.
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr);
            check("readback", q, {24'h0, rows[i].data});
        end
        settle(1);
        check("double drive", 32'(data_double_drive), 32'h1);
        check("high freq pair", {high_freq_a, high_freq_b}, 32'h3);
        check("slow pair on", {slow_mode_a, slow_mode_b}, 32'h3);
        check("swing override on", 32'(swing_override), 32'h1);
        wr(OFS_SLOW_MASTER, 8'h00);
        settle(1);
        check("slow pair off", {slow_mode_a, slow_mode_b}, 32'h0);
        // ====================================================================
        // Unmapped place: refused and reads zero.
        wr(8'h30, 8'hff);
        rd(8'h30);
        check("unmapped error", 32'(e), 32'h1);
        check("unmapped data", q, 32'h0);
        // ====================================================================
        // Full power down, channel A output quiet, then slow wakeup.
        wr(OFS_POWER_DRIVE, 8'h04);
        settle(3);
        check("powered", 32'(analog_enable), 32'h0);
        check("out a while down", 32'(data_out_a), 32'h0);
        wr(OFS_POWER_DRIVE, 8'h00);
        n = 0;
        while (analog_enable !== 1'b1 && n < 100) begin
            settle(1);
            n++;
        end
        check("wakeup window", 32'(n >= WK - 1 && n <= WK + 2), 32'h1);
        n = 0;
        while (data_valid !== 1'b1 && n < 40) begin
            settle(1);
            n++;
        end
        check("valid after wake", 32'(data_valid), 32'h1);
        // ====================================================================
        // Pipeline latency in both output formats, both channels together.
        for (int fmt = 0; fmt < 2; fmt++) begin
            wr(OFS_AUX_CONTROL, 8'(fmt));
            flip = fmt ? 14'h0 : MIDCODE;
            settle(20);
            for (int j = 0; j < 6; j++) begin
                settle(1);
                k = hist_a.size() - 1;
                check("out a", 32'(data_out_a), 32'(hist_a[k-15] ^ flip));
                check("out b", 32'(data_out_b), 32'(hist_b[k-15] ^ flip));
            end
        end
        // ====================================================================
        // Swing code applies with the override at 11, override cleared to 00, then a second reset.
        wr(OFS_AUX_CONTROL, 8'h6c); // Override already set above.
        settle(1);
        check("swing code", 32'(swing_code), 32'h1b);
        settle(17);
        k = hist_a.size() - 1;
        check("pedestal a", 32'(data_out_a), 32'((hist_a[k-15] - 14'h1) ^ MIDCODE));
        wr(OFS_SWING_ENABLE, 8'h00);
        settle(1);
        check("swing override off", 32'(swing_override), 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_HF_SELECT_A);
        check("second reset", q, 32'h0);
        close_out();
    end
endmodule // tb_acrb_bank
